// ### verilog/asr_consts.svh
// Constants of the asynchronous serial transceiver: offsets, fields, resets, timing
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
// ==================================================
// Register offsets (plain register port, byte-wide data)
`define ASR_OFS_MODE 3'h0
`define ASR_OFS_STATUS 3'h1
`define ASR_OFS_BAUD 3'h2
`define ASR_OFS_TXSHIFT 3'h3
`define ASR_OFS_RXBUF 3'h4
// ==================================================
// Mode register fields
`define ASR_MODE_POWER 7
`define ASR_MODE_TXEN 6
`define ASR_MODE_RXEN 5
`define ASR_MODE_PAR_HI 4
`define ASR_MODE_PAR_LO 3
`define ASR_MODE_CHAR8 2
`define ASR_MODE_STOP2 1
`define ASR_MODE_RESET 8'h01
// ==================================================
// Status register fields
`define ASR_STAT_PARITY 2
`define ASR_STAT_FRAMING 1
`define ASR_STAT_OVERRUN 0
// ==================================================
// Baud generator control fields
`define ASR_BAUD_PS_HI 7
`define ASR_BAUD_PS_LO 6
`define ASR_BAUD_DIV_HI 4
`define ASR_BAUD_DIV_LO 0
`define ASR_BAUD_RESET 8'h1f
// ==================================================
// Timing
`define ASR_TXEN_SETTLE_CLKS 2
`endif

// ### verilog/asr_pkg.sv
// Types shared by the asynchronous serial transceiver
package asr_pkg;
  typedef enum logic [1:0] {
    ASR_PAR_NONE = 2'h0,
    ASR_PAR_ZERO = 2'h1,
    ASR_PAR_ODD = 2'h2,
    ASR_PAR_EVEN = 2'h3
  } asr_parity_e;

  typedef enum logic [4:0] {
    ASR_TX_IDLE = 5'b0_0001,
    ASR_TX_START = 5'b0_0010,
    ASR_TX_DATA = 5'b0_0100,
    ASR_TX_PAR = 5'b0_1000,
    ASR_TX_STOP = 5'b1_0000
  } asr_txstate_e;

  typedef enum logic [4:0] {
    ASR_RX_IDLE = 5'b0_0001,
    ASR_RX_START = 5'b0_0010,
    ASR_RX_DATA = 5'b0_0100,
    ASR_RX_PAR = 5'b0_1000,
    ASR_RX_STOP = 5'b1_0000
  } asr_rxstate_e;

  typedef struct packed {
    logic parity;
    logic framing;
    logic overrun;
  } asr_err_s;
endpackage

// ### verilog/asr_baud_tick.sv
// Baud tick generator: base clock prescaler, gated by power
`timescale 1ns/1ns
`default_nettype none
module asr_baud_tick (
  input wire logic clk,
  input wire logic reset,
  input wire logic powerOn,
  input wire logic [1:0] prescale,
  output logic baseTick
);
  logic [3:0] preCount_r;
  logic [3:0] preMask;

  // Prescaler choice: base clock = clk / 2^(prescale+1)
  always_comb begin
    case (prescale)
      2'h0: preMask = 4'h1;
      2'h1: preMask = 4'h3;
      2'h2: preMask = 4'h7;
      default: preMask = 4'hf;
    endcase
  end

  // Base clock held off while power is off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      preCount_r <= 4'h0;
      baseTick <= 1'b0;
    end else if (!powerOn) begin
      preCount_r <= 4'h0;
      baseTick <= 1'b0;
    end else begin
      preCount_r <= preCount_r + 4'h1;
      baseTick <= ((preCount_r & preMask) == preMask);
    end
  end

  base_gated_a: assert property (@(posedge clk) disable iff (reset)
    !$past(powerOn) |-> !baseTick)
    else $error("Base tick while power off");
endmodule
`default_nettype wire

// ### verilog/asr_uart.sv
// Asynchronous serial transceiver with baud generator and error status
`timescale 1ns/1ns
`default_nettype none
`include "asr_consts.svh"
// Operation
// - Even parity: total ones even, else error
// - Odd parity: total ones odd, else error
// - Zero parity sends 0, never checks
// - No parity: no bit, no error
// - Line idles high once power set
// - Write starts frame, LSB first, then idle
// - Transmit done pulse after final stop
// - Falling edge, recheck after divisor, start
// - Shift bits, stop completes, buffer unless overrun
// - Parity error waits until frame end
// - Receiver checks only one stop bit
// - Any error flag raises error pulse
// - Status read returns and clears flags
// - Framing on bad stop, overrun on unread
// - Two agreeing base samples filter input
// - Base clock runs only while powered
// - Transmit counter held unless power and enable
// - Receive counter held, runs per frame
// - Prescaler select, divisor 1..31 (0 acts as 32), rate base/2k
// - Power off resets status, shift, buffer
// - Start, 7/8 bits, parity, 1/2 stops
// - Receive input idle-high while unpowered
// - Enable clear resets its own circuit
module asr_uart (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic serialRxLine,
  output logic serialTxLine,
  output logic transmitCompleteIrq,
  output logic receiveCompleteIrq,
  output logic receiveErrorIrq
);
  // ==================================================
  // Registers
  logic [7:0] modeReg_r;
  logic [7:0] baudReg_r;
  logic [7:0] txShift_r;
  logic [7:0] rxShift_r;
  logic [7:0] rxBuf_r;
  logic rxBufFull_r;
  asr_pkg::asr_err_s errStat_r;
  logic powerOn, txEn, rxEn, char8, stop2;
  asr_pkg::asr_parity_e parMode;
  logic [4:0] divK;
  logic baseTick;
  logic statusRead, bufRead, txWrite;

  assign powerOn = modeReg_r[`ASR_MODE_POWER];
  assign txEn = modeReg_r[`ASR_MODE_TXEN] & powerOn;
  assign rxEn = modeReg_r[`ASR_MODE_RXEN] & powerOn;
  assign char8 = modeReg_r[`ASR_MODE_CHAR8];
  assign stop2 = modeReg_r[`ASR_MODE_STOP2];
  assign parMode = asr_pkg::asr_parity_e'(modeReg_r[`ASR_MODE_PAR_HI:`ASR_MODE_PAR_LO]);
  assign divK = baudReg_r[`ASR_BAUD_DIV_HI:`ASR_BAUD_DIV_LO];
  assign statusRead = regRead && regAddr == `ASR_OFS_STATUS;
  assign bufRead = regRead && regAddr == `ASR_OFS_RXBUF;
  assign txWrite = regWrite && regAddr == `ASR_OFS_TXSHIFT && txEn;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modeReg_r <= `ASR_MODE_RESET;
      baudReg_r <= `ASR_BAUD_RESET;
    end else if (regWrite) begin
      if (regAddr == `ASR_OFS_MODE) begin
        modeReg_r <= {regWrData[7:1], 1'b1};
      end else if (regAddr == `ASR_OFS_BAUD) begin
        baudReg_r <= regWrData;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      if (regAddr == `ASR_OFS_MODE) begin
        regRdData <= modeReg_r;
      end else if (regAddr == `ASR_OFS_STATUS) begin
        regRdData <= {5'h00, errStat_r};
      end else if (regAddr == `ASR_OFS_BAUD) begin
        regRdData <= baudReg_r;
      end else if (regAddr == `ASR_OFS_TXSHIFT) begin
        regRdData <= txShift_r;
      end else if (regAddr == `ASR_OFS_RXBUF) begin
        regRdData <= rxBuf_r;
      end else begin
        regRdData <= 8'h00;
      end
    end else begin
      regRdData <= 8'h00;
    end
  end

  // ==================================================
  // Base clock
  asr_baud_tick baudGen (
    .clk(clk),
    .reset(reset),
    .powerOn(powerOn),
    .prescale(baudReg_r[`ASR_BAUD_PS_HI:`ASR_BAUD_PS_LO]),
    .baseTick(baseTick)
  );

  // ==================================================
  // Transmitter
  asr_pkg::asr_txstate_e txState_r;
  logic [4:0] txCount_r;
  logic txHalf_r;
  logic [2:0] txBit_r;
  logic [7:0] txData_r;
  logic txPar;
  logic txBitEnd;
  logic [2:0] lastBit;

  assign lastBit = char8 ? 3'h7 : 3'h6;
  // Even parity makes total even; odd inverts; zero forces 0
  assign txPar = (parMode == asr_pkg::ASR_PAR_ZERO) ? 1'b0 :
                 ((char8 ? ^txData_r : ^txData_r[6:0]) ^ (parMode == asr_pkg::ASR_PAR_ODD));
  // One bit = two halves of k base clocks, rate = base / 2k
  assign txBitEnd = baseTick && txCount_r == divK - 5'h1 && txHalf_r;

  // Counter held while disabled, cleared on a write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txCount_r <= 5'h00;
      txHalf_r <= 1'b0;
    end else if (!txEn || txWrite) begin
      txCount_r <= 5'h00;
      txHalf_r <= 1'b0;
    end else if (baseTick) begin
      if (txCount_r == divK - 5'h1) begin
        txCount_r <= 5'h00;
        txHalf_r <= ~txHalf_r;
      end else begin
        txCount_r <= txCount_r + 5'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txShift_r <= 8'h00;
    end else if (!powerOn) begin
      txShift_r <= 8'h00;
    end else if (txWrite) begin
      txShift_r <= regWrData;
    end
  end

  // Frame: start, LSB-first data, parity, stops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txState_r <= asr_pkg::ASR_TX_IDLE;
      txBit_r <= 3'h0;
      txData_r <= 8'h00;
      serialTxLine <= 1'b1;
      transmitCompleteIrq <= 1'b0;
    end else if (!txEn) begin
      txState_r <= asr_pkg::ASR_TX_IDLE;
      txBit_r <= 3'h0;
      serialTxLine <= 1'b1;
      transmitCompleteIrq <= 1'b0;
    end else begin
      transmitCompleteIrq <= 1'b0;
      case (txState_r)
        asr_pkg::ASR_TX_IDLE: begin
          serialTxLine <= 1'b1;
          if (txWrite) begin
            txData_r <= regWrData;
            txState_r <= asr_pkg::ASR_TX_START;
            serialTxLine <= 1'b0;
          end
        end
        asr_pkg::ASR_TX_START: begin
          if (txBitEnd) begin
            txState_r <= asr_pkg::ASR_TX_DATA;
            txBit_r <= 3'h0;
            serialTxLine <= txData_r[0];
          end
        end
        asr_pkg::ASR_TX_DATA: begin
          if (txBitEnd) begin
            if (txBit_r == lastBit) begin
              if (parMode == asr_pkg::ASR_PAR_NONE) begin
                txState_r <= asr_pkg::ASR_TX_STOP;
                txBit_r <= 3'h0;
                serialTxLine <= 1'b1;
              end else begin
                txState_r <= asr_pkg::ASR_TX_PAR;
                serialTxLine <= txPar;
              end
            end else begin
              txBit_r <= txBit_r + 3'h1;
              serialTxLine <= txData_r[txBit_r + 3'h1];
            end
          end
        end
        asr_pkg::ASR_TX_PAR: begin
          if (txBitEnd) begin
            txState_r <= asr_pkg::ASR_TX_STOP;
            txBit_r <= 3'h0;
            serialTxLine <= 1'b1;
          end
        end
        asr_pkg::ASR_TX_STOP: begin
          if (txBitEnd) begin
            if (stop2 && txBit_r == 3'h0) begin
              txBit_r <= 3'h1;
            end else begin
              txState_r <= asr_pkg::ASR_TX_IDLE;
              transmitCompleteIrq <= 1'b1;
            end
          end
        end
        default: txState_r <= asr_pkg::ASR_TX_IDLE;
      endcase
    end
  end

  // ==================================================
  // Receive input: two flops, then base-clock match filter
  logic rxSync1_r, rxSync2_r, rxSampA_r, rxSampB_r, rxFilt_r, rxFiltPrev_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxSync1_r <= 1'b1;
      rxSync2_r <= 1'b1;
    end else begin
      rxSync1_r <= serialRxLine;
      rxSync2_r <= rxSync1_r;
    end
  end

  // Filter output moves only when two base samples agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxSampA_r <= 1'b1;
      rxSampB_r <= 1'b1;
      rxFilt_r <= 1'b1;
      rxFiltPrev_r <= 1'b1;
    end else if (!powerOn) begin
      rxSampA_r <= 1'b1;
      rxSampB_r <= 1'b1;
      rxFilt_r <= 1'b1;
      rxFiltPrev_r <= 1'b1;
    end else begin
      rxFiltPrev_r <= rxFilt_r;
      if (baseTick) begin
        rxSampA_r <= rxSync2_r;
        rxSampB_r <= rxSampA_r;
        if (rxSampA_r == rxSampB_r) begin
          rxFilt_r <= rxSampB_r;
        end
      end
    end
  end

  // ==================================================
  // Receiver
  asr_pkg::asr_rxstate_e rxState_r;
  logic [4:0] rxCount_r;
  logic rxHalf_r;
  logic [2:0] rxBit_r;
  logic rxParAcc_r;
  logic rxParBad_r;
  logic rxRun;
  logic rxHalfEnd, rxBitEnd;

  assign rxRun = rxState_r != asr_pkg::ASR_RX_IDLE;
  assign rxHalfEnd = baseTick && rxCount_r == divK - 5'h1;
  assign rxBitEnd = rxHalfEnd && rxHalf_r;

  // Counter held when idle or disabled; counts one frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxCount_r <= 5'h00;
      rxHalf_r <= 1'b0;
    end else if (!rxEn || !rxRun) begin
      rxCount_r <= 5'h00;
      rxHalf_r <= 1'b0;
    end else if (baseTick) begin
      if (rxCount_r == divK - 5'h1) begin
        rxCount_r <= 5'h00;
        rxHalf_r <= ~rxHalf_r;
      end else begin
        rxCount_r <= rxCount_r + 5'h1;
      end
    end
  end

  logic frameDone_r;
  logic frameBadStop_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxState_r <= asr_pkg::ASR_RX_IDLE;
      rxBit_r <= 3'h0;
      rxShift_r <= 8'h00;
      rxParAcc_r <= 1'b0;
      rxParBad_r <= 1'b0;
      frameDone_r <= 1'b0;
      frameBadStop_r <= 1'b0;
    end else if (!rxEn) begin
      rxState_r <= asr_pkg::ASR_RX_IDLE;
      rxBit_r <= 3'h0;
      frameDone_r <= 1'b0;
      frameBadStop_r <= 1'b0;
    end else begin
      frameDone_r <= 1'b0;
      case (rxState_r)
        asr_pkg::ASR_RX_IDLE: begin
          if (rxFiltPrev_r && !rxFilt_r) begin
            rxState_r <= asr_pkg::ASR_RX_START;
          end
        end
        asr_pkg::ASR_RX_START: begin
          // Mid-start recheck after k base clocks
          if (rxHalfEnd && !rxHalf_r) begin
            if (rxFilt_r) begin
              rxState_r <= asr_pkg::ASR_RX_IDLE;
            end
          end else if (rxBitEnd) begin
            rxState_r <= asr_pkg::ASR_RX_DATA;
            rxBit_r <= 3'h0;
            rxParAcc_r <= 1'b0;
          end
        end
        asr_pkg::ASR_RX_DATA: begin
          if (rxHalfEnd && !rxHalf_r) begin
            rxShift_r <= {rxFilt_r, rxShift_r[7:1]};
            rxParAcc_r <= rxParAcc_r ^ rxFilt_r;
          end else if (rxBitEnd) begin
            if (rxBit_r == lastBit) begin
              if (!char8) begin
                rxShift_r <= {1'b0, rxShift_r[7:1]};
              end
              rxState_r <= (parMode == asr_pkg::ASR_PAR_NONE) ? asr_pkg::ASR_RX_STOP : asr_pkg::ASR_RX_PAR;
              rxParBad_r <= 1'b0;
            end else begin
              rxBit_r <= rxBit_r + 3'h1;
            end
          end
        end
        asr_pkg::ASR_RX_PAR: begin
          // Parity noted, frame continues to stop
          if (rxHalfEnd && !rxHalf_r) begin
            rxParBad_r <= (parMode == asr_pkg::ASR_PAR_EVEN && (rxParAcc_r ^ rxFilt_r)) ||
                          (parMode == asr_pkg::ASR_PAR_ODD && !(rxParAcc_r ^ rxFilt_r));
          end else if (rxBitEnd) begin
            rxState_r <= asr_pkg::ASR_RX_STOP;
          end
        end
        asr_pkg::ASR_RX_STOP: begin
          // Only the first stop bit is examined
          if (rxHalfEnd && !rxHalf_r) begin
            frameDone_r <= 1'b1;
            frameBadStop_r <= !rxFilt_r;
            rxState_r <= asr_pkg::ASR_RX_IDLE;
          end
        end
        default: rxState_r <= asr_pkg::ASR_RX_IDLE;
      endcase
    end
  end

  // ==================================================
  // Completion, buffer, error status
  logic overrunNow;
  assign overrunNow = frameDone_r && rxBufFull_r && !bufRead;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxBuf_r <= 8'h00;
      rxBufFull_r <= 1'b0;
      receiveCompleteIrq <= 1'b0;
    end else if (!powerOn) begin
      rxBuf_r <= 8'h00;
      rxBufFull_r <= 1'b0;
      receiveCompleteIrq <= 1'b0;
    end else begin
      receiveCompleteIrq <= frameDone_r;
      if (frameDone_r && !overrunNow) begin
        rxBuf_r <= rxShift_r;
        rxBufFull_r <= 1'b1;
      end else if (bufRead) begin
        rxBufFull_r <= 1'b0;
      end
    end
  end

  // New errors win over a same-cycle clearing read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      errStat_r <= 3'h0;
      receiveErrorIrq <= 1'b0;
    end else if (!powerOn) begin
      errStat_r <= 3'h0;
      receiveErrorIrq <= 1'b0;
    end else begin
      receiveErrorIrq <= frameDone_r && (rxParBad_r || frameBadStop_r || overrunNow);
      errStat_r.parity <= (frameDone_r && rxParBad_r) || (errStat_r.parity && !statusRead);
      errStat_r.framing <= (frameDone_r && frameBadStop_r) || (errStat_r.framing && !statusRead);
      errStat_r.overrun <= overrunNow || (errStat_r.overrun && !statusRead);
    end
  end

  // ==================================================
  // Checks
  tx_idle_high_a: assert property (@(posedge clk) disable iff (reset)
    (powerOn && txState_r == asr_pkg::ASR_TX_IDLE && !txWrite) |=> serialTxLine)
    else $error("Line not idle high");
  tx_start_low_a: assert property (@(posedge clk) disable iff (reset)
    (txWrite && txState_r == asr_pkg::ASR_TX_IDLE) |=> !serialTxLine)
    else $error("No start bit after write");
  tx_done_stop_a: assert property (@(posedge clk) disable iff (reset)
    transmitCompleteIrq |-> (serialTxLine && txState_r == asr_pkg::ASR_TX_IDLE))
    else $error("Done pulse not after stop");
  tx_count_hold_a: assert property (@(posedge clk) disable iff (reset)
    !txEn |=> (txCount_r == 5'h00))
    else $error("Transmit counter not held");
  rx_count_hold_a: assert property (@(posedge clk) disable iff (reset)
    (!rxEn || !rxRun) |=> (rxCount_r == 5'h00))
    else $error("Receive counter not held");
  status_clear_a: assert property (@(posedge clk) disable iff (reset)
    (statusRead && !frameDone_r) |=> (errStat_r == 3'h0))
    else $error("Status not cleared by read");
  err_irq_a: assert property (@(posedge clk) disable iff (reset)
    receiveErrorIrq |-> (errStat_r != 3'h0))
    else $error("Error pulse without flag");
  zero_par_a: assert property (@(posedge clk) disable iff (reset)
    (parMode inside {asr_pkg::ASR_PAR_ZERO, asr_pkg::ASR_PAR_NONE} && frameDone_r) |=> !errStat_r.parity || $past(errStat_r.parity))
    else $error("Parity error in unchecked mode");
  overrun_keep_a: assert property (@(posedge clk) disable iff (reset)
    overrunNow |=> $stable(rxBuf_r))
    else $error("Buffer overwritten on overrun");
  power_off_a: assert property (@(posedge clk) disable iff (reset)
    !powerOn |=> (rxBuf_r == 8'h00 && txShift_r == 8'h00 && errStat_r == 3'h0))
    else $error("Power off did not reset");

  tx_frame_c: cover property (@(posedge clk) disable iff (reset) transmitCompleteIrq);
  rx_frame_c: cover property (@(posedge clk) disable iff (reset) receiveCompleteIrq);
  rx_error_c: cover property (@(posedge clk) disable iff (reset) receiveErrorIrq);
  overrun_c: cover property (@(posedge clk) disable iff (reset) overrunNow);
endmodule
`default_nettype wire

// ### verification/asr_remote.sv
// Remote serial partner: raw frame sender and line decoder
`timescale 1ns/1ns
`default_nettype none
module asr_remote #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk,
  input wire logic txLine,
  input wire logic [3:0] frameLen,
  output logic rxLine,
  output logic frameSeen,
  output logic [11:0] frameBits
);
  // =====
  // Sender: the caller builds each frame, so faults are only those it asks for
  initial begin
    rxLine = 1'b1;
    frameSeen = 1'b0;
    frameBits = 12'h000;
  end
  task automatic send(input logic [11:0] bits, input int n, input int gap);
    repeat (gap) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxLine <= bits[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxLine <= 1'b1;
  endtask
  // One clock low: too short to pass two agreeing base samples
  task automatic glitch();
    rxLine <= 1'b0;
    @(posedge clk);
    rxLine <= 1'b1;
  endtask
  // =====
  // Decoder: samples each bit at its centre
  always begin
    @(negedge txLine);
    repeat (BIT_CLKS / 2) @(posedge clk);
    frameBits <= 12'h000;
    for (int i = 0; i < 12; i++) begin
      if (i < frameLen) frameBits[i] <= txLine;
      if (i + 1 < frameLen) repeat (BIT_CLKS) @(posedge clk);
    end
    frameSeen <= 1'b1;
    @(posedge clk);
    frameSeen <= 1'b0;
  end
endmodule
`default_nettype wire

// ### verification/async_serial_txrx_with_baud_gen_bench.sv
// Self-checking bench of the asynchronous serial transceiver
`timescale 1ns/1ns
`default_nettype none
`include "asr_consts.svh"
module async_serial_txrx_with_baud_gen_bench;
  // =====
  // Signals
  // Prescale 0 and k = 8: 16 base ticks of 2 clk per bit
  localparam int BITC = 32;
  logic clk, reset, regWrite, regRead, rxLine, txLine, txIrq, rxIrq, errIrq, rdWas, frameSeen;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, mode, lastBuf;
  logic [3:0] frameLen;
  logic [11:0] frameBits;
  logic [11:0] txQ[$];
  logic [7:0] readQ[$];
  logic errQ[$];
  logic [31:0] seed = 32'h2689_a81b;
  int fail_count = 0;
  int tests_run = 0;
  int txSeen = 0;
  int rxSeen = 0;
  time txAt;

  asr_uart DUT (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .serialRxLine(rxLine), .serialTxLine(txLine),
    .transmitCompleteIrq(txIrq), .receiveCompleteIrq(rxIrq), .receiveErrorIrq(errIrq));
  asr_remote #(.BIT_CLKS(BITC)) remote (.clk(clk), .txLine(txLine), .frameLen(frameLen), .rxLine(rxLine),
    .frameSeen(frameSeen), .frameBits(frameBits));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // =====
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected line bits, LSB first, with frame length on top
  function automatic logic [15:0] frame(input logic [7:0] d, input logic bp, input logic bs, input int stops);
    logic [11:0] f;
    int n;
    logic c8;
    logic [1:0] pm;
    c8 = mode[`ASR_MODE_CHAR8];
    pm = mode[`ASR_MODE_PAR_HI:`ASR_MODE_PAR_LO];
    f = {3'h0, d, 1'b0};
    n = c8 ? 9 : 8;
    if (pm == asr_pkg::ASR_PAR_EVEN) f[n] = ^d[6:0] ^ (c8 & d[7]);
    if (pm == asr_pkg::ASR_PAR_ODD) f[n] = ~(^d[6:0] ^ (c8 & d[7]));
    if (pm == asr_pkg::ASR_PAR_ZERO) f[n] = 1'b0;
    if (pm != asr_pkg::ASR_PAR_NONE) begin
      f[n] = f[n] ^ bp;
      n++;
    end
    f[n] = !bs;
    if (stops == 2) f[n + 1] = 1'b1;
    return {4'(n + stops), f};
  endfunction

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic step(inout int n);
    @(posedge clk);
    n++;
    if (n > 1000) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // One strobe cycle, then a quiet cycle; reads note the expected data
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    if (!w) readQ.push_back(d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= w;
    regRead <= !w;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    @(posedge clk);
  endtask

  // Full duplex: one frame each way, then status and, if rdBuf, buffer in that order
  task automatic txrx(input logic [7:0] td, input logic [7:0] rd, input logic bp, input logic bs,
      input logic [2:0] errs, input logic rdBuf);
    logic [15:0] tf, rf;
    int n, t0, r0;
    time tw;
    tf = frame(td, 1'b0, 1'b0, 1 + mode[`ASR_MODE_STOP2]);
    rf = frame(rd, bp, bs, 1);
    txQ.push_back(tf[11:0]);
    errQ.push_back(errs != 3'h0);
    frameLen <= tf[15:12];
    t0 = txSeen;
    r0 = rxSeen;
    n = 0;
    tw = $time;
    bus(1'b1, `ASR_OFS_TXSHIFT, td);
    remote.send(rf[11:0], rf[15:12], rnd() % 64);
    while (txSeen == t0 || rxSeen == r0) step(n);
    n = int'((txAt - tw) / 40) - BITC * int'(tf[15:12]);
    check("txdly", {11'h0, n >= 1 && n <= 5}, 12'h1);
    check("idle", {11'h0, txLine}, 12'h1);
    bus(1'b0, `ASR_OFS_STATUS, {5'h0, errs});
    if (!errs[`ASR_STAT_OVERRUN]) lastBuf = mode[`ASR_MODE_CHAR8] ? rd : {1'b0, rd[6:0]};
    if (rdBuf) bus(1'b0, `ASR_OFS_RXBUF, lastBuf);
  endtask

  // =====
  // Result watcher
  always @(posedge clk) begin
    rdWas <= regRead;
    if (rdWas) check("rd", {4'h0, regRdData}, {4'h0, readQ.size() ? readQ.pop_front() : 8'hxx});
    if (rxIrq || errIrq) begin
      check("rxirq", {10'h0, rxIrq, errIrq}, {11'h1, errQ.size() ? errQ.pop_front() : 1'bx});
      if (rxIrq) rxSeen++;
    end
    if (txIrq) begin
      txAt = $time;
      txSeen++;
    end
    if (frameSeen) check("txfrm", frameBits, txQ.size() ? txQ.pop_front() : 12'hxxx);
  end

  // =====
  // Main sequence
  initial begin
    reset = 1'b1;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    rdWas = 1'b0;
    frameLen = 4'h0;
    mode = `ASR_MODE_RESET;
    lastBuf = 8'h00;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    bus(1'b0, `ASR_OFS_MODE, `ASR_MODE_RESET);
    bus(1'b0, `ASR_OFS_BAUD, `ASR_BAUD_RESET);
    bus(1'b0, 3'h6, 8'h00);
    bus(1'b1, `ASR_OFS_BAUD, 8'h08);
    bus(1'b1, `ASR_OFS_MODE, 8'h81);
    check("idle", {11'h0, txLine}, 12'h1);
    for (int m = 0; m < 16; m++) begin
      mode = {3'b111, 4'(m), 1'b1};
      bus(1'b1, `ASR_OFS_MODE, mode);
      repeat (2 * `ASR_TXEN_SETTLE_CLKS) @(posedge clk);
      txrx(8'(rnd()), 8'(rnd()), m[3:2] == 2'h1, 1'b0, 3'h0, 1'b1);
    end
    mode = 8'hfd;
    bus(1'b1, `ASR_OFS_MODE, mode);
    txrx(8'(rnd()), 8'(rnd()), 1'b1, 1'b0, 3'h4, 1'b1);
    mode = 8'hf5;
    bus(1'b1, `ASR_OFS_MODE, mode);
    txrx(8'(rnd()), 8'(rnd()), 1'b1, 1'b0, 3'h4, 1'b1);
    txrx(8'(rnd()), 8'(rnd()), 1'b0, 1'b1, 3'h2, 1'b1);
    txrx(8'(rnd()), 8'(rnd()), 1'b0, 1'b0, 3'h0, 1'b0);
    txrx(8'(rnd()), 8'(rnd()), 1'b0, 1'b0, 3'h1, 1'b1);
    bus(1'b0, `ASR_OFS_STATUS, 8'h00);
    remote.glitch();
    repeat (BITC * 12) @(posedge clk);
    bus(1'b1, `ASR_OFS_MODE, `ASR_MODE_RESET);
    bus(1'b0, `ASR_OFS_RXBUF, 8'h00);
    bus(1'b0, `ASR_OFS_MODE, `ASR_MODE_RESET);
    end_of_test();
  end
endmodule
`default_nettype wire
